// ### logic/imbl_defines.svh
// Functional notes
// - one enable bit per source; set passes that source to the interrupt, clear blocks it
// - every enable bit is zero after reset, so no interrupt until software enables
// - link-loss enable bit 0 and streaming-gap enable bit 2 are writable everywhere
// - crc-error bit 1 and hot-reset bit 3 writable only as endpoint, else zero
// - completion-status enable field 7:5 writable only as root port, else zero
// - config-access timeout enable bit 8 writable only as root port, else zero
// - error-message enables bits 9, 10, 11 writable only as root port, else zero
// - intx enable bit 16 and msi enable bit 17 writable only as root port
// - inbound-slave error enables bits 20 to 25 are read-write
// - outbound-master error enables bits 26 to 28 are read-write
// - location bits 2:0 hold the function number, always zero, read-only
// - location bits 7:3 report the assigned device number, read-only
// - location bits 15:8 report the assigned bus number, read-only
// - location bits 23:16 hold a writable port number shown to link capabilities
// - interrupt rises only for a pending flag whose enable bit is also set
// - writing one clears a pending flag; error-message flags need an empty queue
`ifndef IMBL_DEFINES_SVH
`define IMBL_DEFINES_SVH

// ---------------------------------------------
// register map
// ---------------------------------------------
`define IMBL_OFS_PEND   12'h138
`define IMBL_OFS_MASK   12'h13C
`define IMBL_OFS_LOC    12'h140
`define IMBL_DATA_W     32

// ---------------------------------------------
// implemented bits per configuration
// ---------------------------------------------
`define IMBL_M_ANY      32'h1FF0_0005
`define IMBL_M_EP       32'h0000_000A
`define IMBL_M_RP       32'h0003_0FE0
`define IMBL_M_ERRMSG   32'h0000_0E00

// ---------------------------------------------
// reset values and fixed fields
// ---------------------------------------------
`define IMBL_RST_WORD   32'h0000_0000
`define IMBL_RST_PORT   8'h00
`define IMBL_FN_NUM     3'h0

// ---------------------------------------------
// bus encodings
// ---------------------------------------------
`define IMBL_HTRANS_NSQ 2'h2
`define IMBL_HRESP_OKAY 1'h0

`endif

// ### logic/imbl_pkg.sv
`default_nettype none
package imbl_pkg;

   // ---------------------------------------------
   // configuration and bus state
   // ---------------------------------------------
   typedef enum logic [0:0] {
      IMBL_CFG_EP = 1'h0,
      IMBL_CFG_RP = 1'h1
   } imbl_cfg_t;

   typedef enum logic [1:0] {
      IMBL_ST_IDLE = 2'h0,
      IMBL_ST_WR   = 2'h1,
      IMBL_ST_RD   = 2'h3
   } imbl_state_t;

   // ---------------------------------------------
   // carriers
   // ---------------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic        ok;
   } imbl_aph_t;

   typedef struct packed {
      logic [7:0] rsvd;
      logic [7:0] port;
      logic [7:0] bus;
      logic [4:0] dev;
      logic [2:0] fn;
   } imbl_loc_t;

endpackage
`default_nettype wire

// ### logic/imbl_pend_flags.sv
`default_nettype none
`include "imbl_defines.svh"
module imbl_pend_flags
   import imbl_pkg::*;
#(
   parameter int          W    = 32,
   parameter logic [W-1:0] IMPL = '1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] evt,
   input  wire logic [W-1:0] clr,
   input  wire logic [W-1:0] hold,
   output var  logic [W-1:0] pend_d,
   output var  logic [W-1:0] pend_q
);

   // ---------------------------------------------
   // elaboration checks
   // ---------------------------------------------
   if (W < 1) begin : g_bad_w
      $error("imbl_pend_flags: W must be at least one");
   end

   // ---------------------------------------------
   // one sticky flag per source
   // ---------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_flag
      // set wins over a clear in the same cycle
      always_comb begin
         pend_d[i] = IMPL[i] & (evt[i] | (pend_q[i] & ~(clr[i] & ~hold[i])));
      end

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            pend_q[i] <= 1'b0;
         end else begin
            pend_q[i] <= pend_d[i];
         end
      end
   end

endmodule
`default_nettype wire

// ### logic/imbl_top.sv
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
`include "imbl_defines.svh"
module imbl_top
   import imbl_pkg::*;
#(
   parameter imbl_cfg_t CFG  = IMBL_CFG_EP,
   parameter int        NSRC = 32
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp,
   input  wire logic [31:0] evt_in,
   input  wire logic        err_queue_empty,
   input  wire logic [4:0]  assigned_dev_num,
   input  wire logic [7:0]  assigned_bus_num,
   output var  logic [7:0]  link_port_num,
   output var  logic        irq
);

   // ---------------------------------------------
   // elaboration checks
   // ---------------------------------------------
   if (NSRC != `IMBL_DATA_W) begin : g_bad_nsrc
      $error("imbl_top: NSRC must equal the 32-bit register width");
   end

   // ---------------------------------------------
   // writable bits for this configuration
   // ---------------------------------------------
   localparam logic [31:0] M_CFG   = (CFG == IMBL_CFG_EP) ? `IMBL_M_EP : `IMBL_M_RP;
   localparam logic [31:0] MASK_WR = `IMBL_M_ANY | M_CFG;

   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   imbl_state_t st_d;
   imbl_state_t st_q;
   imbl_aph_t   aph_d;
   imbl_aph_t   aph_q;
   logic        take;
   logic        wr_pend;
   logic        wr_mask;
   logic        wr_loc;
   logic [31:0] mask_d;
   logic [31:0] mask_q;
   logic [7:0]  port_d;
   logic [7:0]  port_q;
   logic [31:0] clr;
   logic [31:0] hold;
   logic [31:0] pend_d;
   logic [31:0] pend_q;
   imbl_loc_t   loc_d;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic        irq_d;
   logic        irq_q;

   // ---------------------------------------------
   // bus slave: address phase
   // ---------------------------------------------
   // zero wait states, so hready never stalls and every response is okay
   assign hreadyout = 1'b1;
   assign hresp     = `IMBL_HRESP_OKAY;

   always_comb begin
      take  = hsel & (htrans == `IMBL_HTRANS_NSQ) & hready;
      st_d  = IMBL_ST_IDLE;
      aph_d = aph_q;
      if (take) begin
         st_d       = hwrite ? IMBL_ST_WR : IMBL_ST_RD;
         aph_d.addr = haddr[11:0];
         aph_d.ok   = (haddr[31:12] == 20'h0_0000) & (haddr[1:0] == 2'h0);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q  <= IMBL_ST_IDLE;
         aph_q <= '0;
      end else begin
         st_q  <= st_d;
         aph_q <= aph_d;
      end
   end

   // ---------------------------------------------
   // bus slave: write decode in the data phase
   // ---------------------------------------------
   always_comb begin
      wr_pend = 1'b0;
      wr_mask = 1'b0;
      wr_loc  = 1'b0;
      if (st_q != IMBL_ST_WR || !aph_q.ok) begin
         wr_pend = 1'b0;
      end else if (aph_q.addr == `IMBL_OFS_PEND) begin
         wr_pend = 1'b1;
      end else if (aph_q.addr == `IMBL_OFS_MASK) begin
         wr_mask = 1'b1;
      end else if (aph_q.addr == `IMBL_OFS_LOC) begin
         wr_loc = 1'b1;
      end
   end

   // ---------------------------------------------
   // enable mask and port number
   // ---------------------------------------------
   always_comb begin
      mask_d = mask_q;
      port_d = port_q;
      if (wr_mask) begin
         mask_d = hwdata & MASK_WR;
      end
      if (wr_loc) begin
         port_d = hwdata[23:16];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_q <= `IMBL_RST_WORD;
         port_q <= `IMBL_RST_PORT;
      end else begin
         mask_q <= mask_d;
         port_q <= port_d;
      end
   end

   assign link_port_num = port_q;

   // ---------------------------------------------
   // pending event flags
   // ---------------------------------------------
   // error-message flags stay until the error queue has been drained
   always_comb begin
      clr  = wr_pend ? hwdata : `IMBL_RST_WORD;
      hold = err_queue_empty ? `IMBL_RST_WORD : `IMBL_M_ERRMSG;
   end

   imbl_pend_flags #(
      .W    (32),
      .IMPL (MASK_WR)
   ) u_pend (
      .clk     (clk),
      .sys_rst (sys_rst),
      .evt     (evt_in),
      .clr     (clr),
      .hold    (hold),
      .pend_d  (pend_d),
      .pend_q  (pend_q)
   );

   // ---------------------------------------------
   // location word
   // ---------------------------------------------
   always_comb begin
      loc_d      = '0;
      loc_d.fn   = `IMBL_FN_NUM;
      loc_d.dev  = assigned_dev_num;
      loc_d.bus  = assigned_bus_num;
      loc_d.port = port_d;
   end

   // ---------------------------------------------
   // read data
   // ---------------------------------------------
   // next-state values are read so a write right before a read is seen
   always_comb begin
      rdata_d = `IMBL_RST_WORD;
      if (!take || hwrite || haddr[31:12] != 20'h0_0000 || haddr[1:0] != 2'h0) begin
         rdata_d = `IMBL_RST_WORD;
      end else if (haddr[11:0] == `IMBL_OFS_PEND) begin
         rdata_d = pend_d;
      end else if (haddr[11:0] == `IMBL_OFS_MASK) begin
         rdata_d = mask_d;
      end else if (haddr[11:0] == `IMBL_OFS_LOC) begin
         rdata_d = loc_d;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= `IMBL_RST_WORD;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign hrdata = rdata_q;

   // ---------------------------------------------
   // interrupt line
   // ---------------------------------------------
   // one register stage keeps the pin glitch free at a cost of one cycle
   always_comb begin
      irq_d = |(pend_q & mask_q);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign irq = irq_q;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic rd_mask_dp;
   logic rd_loc_dp;
   logic rd_pend_dp;
   assign rd_mask_dp = (st_q == IMBL_ST_RD) & aph_q.ok & (aph_q.addr == `IMBL_OFS_MASK);
   assign rd_loc_dp  = (st_q == IMBL_ST_RD) & aph_q.ok & (aph_q.addr == `IMBL_OFS_LOC);
   assign rd_pend_dp = (st_q == IMBL_ST_RD) & aph_q.ok & (aph_q.addr == `IMBL_OFS_PEND);

   mask_write_a: assert property (
      wr_mask |=> mask_q == ($past(hwdata) & MASK_WR)
   ) else $error("mask write not stored");

   mask_reset_a: assert property (
      $fell(sys_rst) |-> mask_q == `IMBL_RST_WORD && !irq
   ) else $error("mask not zero after reset");

   base_bits_a: assert property (
      wr_mask |=> mask_q[0] == $past(hwdata[0]) && mask_q[2] == $past(hwdata[2])
   ) else $error("bits 0 or 2 not writable");

   ep_bits_a: assert property (
      (CFG != IMBL_CFG_EP) |-> mask_q[1] == 1'b0 && mask_q[3] == 1'b0
   ) else $error("endpoint-only bits set outside endpoint");

   cpl_field_a: assert property (
      (CFG != IMBL_CFG_RP) |-> mask_q[7:5] == 3'h0
   ) else $error("completion field set outside root port");

   cfg_tmo_a: assert property (
      (CFG == IMBL_CFG_RP) && wr_mask |=> mask_q[8] == $past(hwdata[8])
   ) else $error("timeout enable not writable as root port");

   errmsg_bits_a: assert property (
      (CFG != IMBL_CFG_RP) |-> mask_q[11:9] == 3'h0
   ) else $error("error-message enables set outside root port");

   intr_bits_a: assert property (
      (CFG != IMBL_CFG_RP) |-> mask_q[17:16] == 2'h0
   ) else $error("intx or msi enable set outside root port");

   slave_bits_a: assert property (
      wr_mask |=> mask_q[25:20] == $past(hwdata[25:20])
   ) else $error("slave error enables not writable");

   master_bits_a: assert property (
      wr_mask |=> mask_q[28:26] == $past(hwdata[28:26])
   ) else $error("master error enables not writable");

   loc_fn_a: assert property (
      rd_loc_dp |-> hrdata[2:0] == `IMBL_FN_NUM
   ) else $error("function number not zero");

   loc_dev_a: assert property (
      rd_loc_dp |-> hrdata[7:3] == $past(assigned_dev_num)
   ) else $error("device number mismatch");

   loc_bus_a: assert property (
      rd_loc_dp |-> hrdata[15:8] == $past(assigned_bus_num)
   ) else $error("bus number mismatch");

   port_num_a: assert property (
      wr_loc |=> link_port_num == $past(hwdata[23:16])
      ##1 ($past(wr_loc) || link_port_num == $past(link_port_num))
   ) else $error("port number not written or not held");

   irq_gate_a: assert property (
      (mask_q == `IMBL_RST_WORD) [*2] |-> !irq
   ) else $error("interrupt without enabled source");

   clear_w1c_a: assert property (
      wr_pend && hwdata[0] && !evt_in[0] |=> !pend_q[0]
   ) else $error("write one did not clear flag");

   errmsg_hold_a: assert property (
      wr_pend && !err_queue_empty && (pend_q & `IMBL_M_ERRMSG) != '0
      |=> (pend_q & `IMBL_M_ERRMSG) == (($past(pend_q) | $past(evt_in)) & `IMBL_M_ERRMSG)
   ) else $error("error-message flag cleared before drain");

   set_wins_a: assert property (
      evt_in[0] |=> pend_q[0]
   ) else $error("event lost");

   rsvd_zero_a: assert property (
      rd_mask_dp || rd_pend_dp |-> (hrdata & ~MASK_WR) == '0
   ) else $error("reserved bits read nonzero");

   rsvd_loc_a: assert property (
      rd_loc_dp |-> hrdata[31:24] == 8'h00
   ) else $error("reserved location bits nonzero");

   irq_or_a: assert property (
      ##1 irq == $past(|(pend_q & mask_q))
   ) else $error("interrupt not or of enabled flags");

   // read-back shows the registers as they stand after the address edge
   mask_hold_a: assert property (
      !wr_mask |=> mask_q == $past(mask_q)
   ) else $error("mask changed without a write");

   mask_read_a: assert property (
      rd_mask_dp |-> hrdata == mask_q
   ) else $error("mask read-back mismatch");

   loc_port_a: assert property (
      rd_loc_dp |-> hrdata[23:16] == link_port_num
   ) else $error("port number read-back mismatch");

   pend_read_a: assert property (
      rd_pend_dp |-> hrdata == pend_q
   ) else $error("pending read-back mismatch");

   rdata_idle_a: assert property (
      st_q != IMBL_ST_RD |-> hrdata == `IMBL_RST_WORD
   ) else $error("read data outside a read data phase");

   irq_rise_c: cover property (!irq ##1 irq);
   wr_then_rd_c: cover property (wr_mask ##0 take && !hwrite);
   hold_c: cover property (wr_pend && !err_queue_empty && pend_q[9]);
   clr_irq_c: cover property (irq ##1 wr_pend ##2 !irq);
   errmsg_clr_c: cover property (wr_pend && err_queue_empty && pend_q[9]);

endmodule
`default_nettype wire

// ### tb/imbl_host_model.sv
`default_nettype none
// ---------------------------------------------
// register software seen from the bus
// ---------------------------------------------
module imbl_host_model (
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [63:0] rdata,
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      hsel   = 1'h0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end

   // single word transfer; no fixed latency assumed, bench timeout ends a hang
   // a write of ones to the pending word is how software clears flags
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [63:0] r);
      @(posedge clk);
      hsel   <= 1'h1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = rdata;
      // released data: show something other than the last value
      hwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ### tb/interrupt_mask_and_bus_location_tb.sv
`default_nettype none
module interrupt_mask_and_bus_location_tb;
   import imbl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        rdy;
   logic [31:0] rd_ep;
   logic [31:0] rd_rp;
   logic [31:0] evt;
   logic        eqe;
   logic [4:0]  dev;
   logic [7:0]  bus;
   logic [7:0]  port_ep;
   logic [7:0]  port_rp;
   logic        irq_ep;
   logic        irq_rp;
   logic        hresp_ep;
   logic        hresp_rp;
   logic        rdy_rp;
   int          err_count;
   int          cmp_count;
   int          cyc;
   int unsigned wm [2];
   int unsigned mk [2];
   int unsigned pd [2];
   logic [63:0] r;
   logic [31:0] d;

   // ---------------------------------------------
   // two configurations on one shared bus
   // ---------------------------------------------
   imbl_top #(.CFG(IMBL_CFG_EP), .NSRC(32)) imbl_top_inst (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hrdata(rd_ep), .hresp(hresp_ep),
      .evt_in(evt), .err_queue_empty(eqe), .assigned_dev_num(dev), .assigned_bus_num(bus),
      .link_port_num(port_ep), .irq(irq_ep));
   imbl_top #(.CFG(IMBL_CFG_RP), .NSRC(32)) imbl_top_inst_rp (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy_rp), .hrdata(rd_rp), .hresp(hresp_rp),
      .evt_in(evt), .err_queue_empty(eqe), .assigned_dev_num(dev), .assigned_bus_num(bus),
      .link_port_num(port_rp), .irq(irq_rp));
   imbl_host_model imbl_host_model_inst (
      .clk(clk), .hready(rdy), .rdata({rd_rp, rd_ep}), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // ---------------------------------------------
   // clock, timeout, checking
   // ---------------------------------------------
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // whole run is a few hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic ck2(input string nm, input logic [63:0] v, input logic [31:0] e0, input logic [31:0] e1);
      chk(nm, v[31:0], e0);
      chk(nm, v[63:32], e1);
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      void'($urandom(97017));
      sys_rst = 1'b1;
      evt     = 32'h0;
      eqe     = 1'b1;
      dev     = 5'($urandom);
      bus     = 8'($urandom);
      wm[0]   = 32'h1FF0_000F;
      wm[1]   = 32'h1FF3_0FE5;
      pd      = '{0, 0};
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;

      imbl_host_model_inst.xfer(1'b0, 32'h13C, 32'h0, r);
      ck2("mask", r, 32'h0, 32'h0);
      imbl_host_model_inst.xfer(1'b0, 32'h140, 32'h0, r);
      ck2("loc", r, {16'h0, bus, dev, 3'h0}, {16'h0, bus, dev, 3'h0});
      chk("irq", {31'h0, irq_ep | irq_rp}, 32'h0);
      $display("test reset done");

      // ones first, so every writable and reserved bit is tried
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         imbl_host_model_inst.xfer(1'b1, 32'h13C, d, r);
         imbl_host_model_inst.xfer(1'b0, 32'h13C, 32'h0, r);
         ck2("mask", r, d & wm[0], d & wm[1]);
      end
      $display("test mask done");

      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         @(posedge clk);
         dev <= 5'($urandom);
         bus <= 8'($urandom);
         imbl_host_model_inst.xfer(1'b1, 32'h140, d, r);
         imbl_host_model_inst.xfer(1'b0, 32'h140, 32'h0, r);
         ck2("loc", r, {8'h0, d[23:16], bus, dev, 3'h0}, {8'h0, d[23:16], bus, dev, 3'h0});
         chk("port", {port_rp, port_ep}, {d[23:16], d[23:16]});
      end
      imbl_host_model_inst.xfer(1'b1, 32'h144, 32'hFFFF_FFFF, r);
      imbl_host_model_inst.xfer(1'b0, 32'h144, 32'h0, r);
      ck2("unmapped", r, 32'h0, 32'h0);
      chk("bus resp", {30'h0, hresp_rp, hresp_ep}, 32'h0);
      chk("bus ready", {30'h0, rdy_rp, rdy}, 32'h3);
      $display("test location done");

      // first pass with mask clear: a pending flag alone keeps irq low
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 32'h0 : $urandom;
         mk[0] = d & wm[0];
         mk[1] = d & wm[1];
         imbl_host_model_inst.xfer(1'b1, 32'h13C, d, r);
         d = $urandom;
         @(posedge clk);
         evt <= d;
         eqe <= 1'($urandom);
         @(posedge clk);
         evt <= 32'h0;
         for (int c = 0; c < 2; c++) pd[c] |= d & wm[c];
         repeat (2) @(posedge clk);
         #1;
         chk("irq", {30'h0, irq_rp, irq_ep}, {30'h0, (pd[1] & mk[1]) != 0, (pd[0] & mk[0]) != 0});
         imbl_host_model_inst.xfer(1'b0, 32'h138, 32'h0, r);
         ck2("pend", r, pd[0], pd[1]);
         imbl_host_model_inst.xfer(1'b1, 32'h138, 32'hFFFF_FFFF, r);
         for (int c = 0; c < 2; c++) pd[c] &= (eqe === 1'b1) ? 32'h0 : 32'h0000_0E00;
         repeat (2) @(posedge clk);
         #1;
         chk("irq", {30'h0, irq_rp, irq_ep}, {30'h0, (pd[1] & mk[1]) != 0, (pd[0] & mk[0]) != 0});
         imbl_host_model_inst.xfer(1'b0, 32'h138, 32'h0, r);
         ck2("pend", r, pd[0], pd[1]);
      end
      $display("test interrupt done");
      close_out();
   end
endmodule
`default_nettype wire
